// ==== verilog/gpp_ports.sv ====
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
// Contract
// (RL1) Port B direction 1 drives pin; 0 leaves it high-impedance input.
// (RL2) Reset clears all port B direction bits.
// (RL3) Port B read returns latch for outputs, pin level for inputs.
// (RL4) Data latch writes always accepted; inputs never affected.
// (RL5) Reset leaves data latches untouched.
// (RL6) Converter channel selection forces port B pin to analog path.
// (RL7) Software loads latch before turning a pin to output.
// (RL8) Port C is seven bits; reset clears its direction bits.
// (RL9) Port C read returns latch for outputs, pin for inputs.
// (RL10) Port C pullup enable 1 pulls input pin up; 0 floats.
// (RL11) Output direction always disconnects the pullup.
// (RL12) CAN enable gives port C pins 1 and 0 to CAN.
// (RL13) Timer 1 channel selects claim port D pins 7 and 6.
// (RL14) Timer 2 channels 1 and 0 claim port D pins 5 and 4.
// (RL15) SPI disabled releases port D pins 3, 2, 1 to GPIO.
// (RL16) Port D pin 0 is GPIO when SPI off or master.
// (RL17) Direction ignored on SPI pins but still selects read source.
// (RL18) Port D read returns latch for outputs, pin for inputs.
// (RL19) Reset clears port D direction; 1 enables output buffer.
// (RL20) Port D pullup 1 connects pullup; output disables it.
// (RL21) Unused port C bit 7 reads zero, ignores writes.
module gpp_ports #(
    parameter int unsigned PB_W = 8,
    parameter int unsigned PC_W = 7,
    parameter int unsigned PD_W = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic [gpp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [gpp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] i_analog_inputs_low,
    input wire logic [7:0] i_port_b_pin,
    output logic [7:0] o_port_b_out,
    output logic [7:0] o_port_b_oe,
    output logic [7:0] o_port_b_analog,
    input wire logic [6:0] i_port_c_pin,
    output logic [6:0] o_port_c_out,
    output logic [6:0] o_port_c_oe,
    output logic [6:0] o_port_c_pullup,
    input wire logic i_can_tx,
    output logic o_can_rx,
    input wire logic [7:0] i_port_d_pin,
    output logic [7:0] o_port_d_out,
    output logic [7:0] o_port_d_oe,
    output logic [7:0] o_port_d_pullup,
    input wire logic [7:0] i_periph_out,
    input wire logic [7:0] i_periph_oe,
    output logic [7:0] o_periph_in,
    output logic o_serial_periph_enable,
    output logic o_serial_master_select,
    output logic o_can_pin_enable,
    output logic [3:0] o_edge_level_select
);
    import gpp_pkg::*;

    initial begin
        if (PB_W != 8 || PC_W != 7 || PD_W != 8) begin
            $error("gpp_ports: port widths are fixed at 8, 7 and 8");
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [7:0] pb_data_reg;
    logic [6:0] pc_data_reg;
    logic [7:0] pd_data_reg;
    logic [7:0] pb_dir_reg;
    logic [6:0] pc_dir_reg;
    logic [7:0] pd_dir_reg;
    logic [6:0] pc_pue_reg;
    logic [7:0] pd_pue_reg;
    logic [6:0] ctrl_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_held_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // ---------------------------------------------------------------
    // Write channel decode
    // ---------------------------------------------------------------
    // Address and data may arrive in either order; each is held until both are here.
    wire aw_take = s_axi_awvalid && !aw_held_reg && !bvalid_reg;
    wire w_take = s_axi_wvalid && !w_held_reg && !bvalid_reg;
    wire [ADDR_W-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
    wire wr_lane0 = w_held_reg ? wstrb_reg[0] : s_axi_wstrb[0];
    wire aw_have = aw_held_reg || aw_take;
    wire w_have = w_held_reg || w_take;
    wire wr_fire = aw_have && w_have && !bvalid_reg && i_clk_en;
    wire [5:0] wr_idx = wr_addr[ADDR_W-1:2];
    wire wr_ok = (wr_addr[1:0] == 2'b00) && (wr_idx >= IDX_PORT_B_DATA[5:0])
        && (wr_idx <= IDX_PERIPH_CTRL[5:0]);
    wire wr_en = wr_fire && wr_ok && wr_lane0;
    wire [7:0] wb = wr_data[7:0];
    wire we_pb_data = wr_en && (wr_idx == IDX_PORT_B_DATA[5:0]);
    wire we_pc_data = wr_en && (wr_idx == IDX_PORT_C_DATA[5:0]);
    wire we_pd_data = wr_en && (wr_idx == IDX_PORT_D_DATA[5:0]);
    wire we_pb_dir = wr_en && (wr_idx == IDX_PORT_B_DIR[5:0]);
    wire we_pc_dir = wr_en && (wr_idx == IDX_PORT_C_DIR[5:0]);
    wire we_pd_dir = wr_en && (wr_idx == IDX_PORT_D_DIR[5:0]);
    wire we_pc_pue = wr_en && (wr_idx == IDX_PORT_C_PUE[5:0]);
    wire we_pd_pue = wr_en && (wr_idx == IDX_PORT_D_PUE[5:0]);
    wire we_ctrl = wr_en && (wr_idx == IDX_PERIPH_CTRL[5:0]);

    assign s_axi_awready = !aw_held_reg && !bvalid_reg && i_clk_en;
    assign s_axi_wready = !w_held_reg && !bvalid_reg && i_clk_en;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ---------------------------------------------------------------
    // Peripheral ownership
    // ---------------------------------------------------------------
    wire can_en = ctrl_reg[BIT_CAN_EN];
    wire spi_en = ctrl_reg[BIT_SPI_EN];
    wire spi_mstr = ctrl_reg[BIT_SPI_MSTR];
    logic [7:0] pd_owned;
    logic [1:0] pc_owned;
    // (RL12) CAN pin claim
    assign pc_owned = {can_en, can_en};
    // (RL15) SPI pins release
    // (RL16) Slave select release
    // (RL13) Timer 1 claim
    // (RL14) Timer 2 claim
    assign pd_owned = {ctrl_reg[BIT_TIMER1_CHANNEL1_PIN_EN], ctrl_reg[BIT_T1CH0_EN],
        ctrl_reg[BIT_TIMER2_CHANNEL1_PIN_EN], ctrl_reg[BIT_T2CH0_EN],
        spi_en, spi_en, spi_en, spi_en && !spi_mstr};

    assign o_serial_periph_enable = spi_en;
    assign o_serial_master_select = spi_mstr;
    assign o_can_pin_enable = can_en;
    assign o_edge_level_select = ctrl_reg[BIT_TIMER2_CHANNEL1_PIN_EN:BIT_T1CH0_EN];
    assign o_periph_in = i_port_d_pin;
    assign o_can_rx = i_port_c_pin[1];

    // ---------------------------------------------------------------
    // Pin drivers
    // ---------------------------------------------------------------
    // Analog selection wins over everything; the digital driver is cut off.
    // (RL6) Analog override
    assign o_port_b_analog = i_analog_inputs_low;
    // (RL1) Port B buffer enable
    assign o_port_b_oe = pb_dir_reg & ~i_analog_inputs_low;
    assign o_port_b_out = pb_data_reg;

    // Pin 1 receives for CAN, pin 0 transmits for it.
    assign o_port_c_oe = {pc_dir_reg[6:2], pc_owned[1] ? 1'b0 : pc_dir_reg[1],
        pc_owned[0] ? 1'b1 : pc_dir_reg[0]};
    assign o_port_c_out = {pc_data_reg[6:1], pc_owned[0] ? i_can_tx : pc_data_reg[0]};
    // (RL10) Port C pullup
    // (RL11) Pullup off for outputs
    assign o_port_c_pullup = pc_pue_reg & ~o_port_c_oe;

    // (RL17) Direction ignored on owned pins
    // (RL19) Port D buffer enable
    assign o_port_d_oe = (pd_owned & i_periph_oe) | (~pd_owned & pd_dir_reg);
    assign o_port_d_out = (pd_owned & i_periph_out) | (~pd_owned & pd_data_reg);
    // (RL20) Port D pullup
    assign o_port_d_pullup = pd_pue_reg & ~o_port_d_oe;

    // ---------------------------------------------------------------
    // Read decode
    // ---------------------------------------------------------------
    // Reading an analog-selected pin as digital draws current; software must avoid it.
    wire [5:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
    wire rd_ok = (s_axi_araddr[1:0] == 2'b00) && (rd_idx >= IDX_PORT_B_DATA[5:0])
        && (rd_idx <= IDX_PERIPH_CTRL[5:0]);
    // (RL3) Port B read select
    wire [7:0] pb_rd = (pb_dir_reg & pb_data_reg) | (~pb_dir_reg & i_port_b_pin);
    // (RL9) Port C read select
    wire [6:0] pc_rd = (pc_dir_reg & pc_data_reg) | (~pc_dir_reg & i_port_c_pin);
    // (RL18) Port D read select
    wire [7:0] pd_rd = (pd_dir_reg & pd_data_reg) | (~pd_dir_reg & i_port_d_pin);
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        // (RL21) Bit 7 reads zero
        unique case (rd_idx)
            IDX_PORT_B_DATA[5:0]: rd_byte = pb_rd;
            IDX_PORT_C_DATA[5:0]: rd_byte = {1'b0, pc_rd};
            IDX_PORT_D_DATA[5:0]: rd_byte = pd_rd;
            IDX_PORT_B_DIR[5:0]: rd_byte = pb_dir_reg;
            IDX_PORT_C_DIR[5:0]: rd_byte = {1'b0, pc_dir_reg};
            IDX_PORT_D_DIR[5:0]: rd_byte = pd_dir_reg;
            IDX_PORT_C_PUE[5:0]: rd_byte = {1'b0, pc_pue_reg};
            IDX_PORT_D_PUE[5:0]: rd_byte = pd_pue_reg;
            IDX_PERIPH_CTRL[5:0]: rd_byte = {1'b0, ctrl_reg};
            default: rd_byte = 8'h00;
        endcase
    end
    wire rd_fire = s_axi_arvalid && !rvalid_reg && i_clk_en;
    assign s_axi_arready = !rvalid_reg && i_clk_en;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ---------------------------------------------------------------
    // Bus handshake state
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (i_clk_en) begin
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held_reg <= 1'b1;
                    awaddr_reg <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held_reg <= 1'b1;
                    wdata_reg <= s_axi_wdata;
                    wstrb_reg <= s_axi_wstrb;
                end
                if (bvalid_reg && s_axi_bready) begin
                    bvalid_reg <= 1'b0;
                end
            end
            if (rd_fire) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= {24'h00_0000, rd_byte};
                rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            // (RL2) Port B inputs
            pb_dir_reg <= DIR_RST;
            // (RL8) Port C inputs
            pc_dir_reg <= DIR_RST[6:0];
            // (RL19) Port D inputs
            pd_dir_reg <= DIR_RST;
            pc_pue_reg <= PUE_RST[6:0];
            pd_pue_reg <= PUE_RST;
            ctrl_reg <= CTRL_RST;
        end else if (i_clk_en) begin
            if (we_pb_dir) pb_dir_reg <= wb;
            if (we_pc_dir) pc_dir_reg <= wb[6:0] & PORT_C_MASK;
            if (we_pd_dir) pd_dir_reg <= wb;
            if (we_pc_pue) pc_pue_reg <= wb[6:0];
            if (we_pd_pue) pd_pue_reg <= wb;
            if (we_ctrl) ctrl_reg <= wb[CTRL_W-1:0];
        end
    end

    // ---------------------------------------------------------------
    // Data latches
    // ---------------------------------------------------------------
    // No reset here on purpose: latch contents survive reset.
    // (RL5) Latches kept over reset
    // (RL4) Writes always land
    always_ff @(posedge i_ref_clk) begin
        if (i_clk_en) begin
            if (we_pb_data) pb_data_reg <= wb;
            if (we_pc_data) pc_data_reg <= wb[6:0];
            if (we_pd_data) pd_data_reg <= wb;
        end
    end
endmodule // gpp_ports

// ==== pkg/gpp_pkg.sv ====
package gpp_pkg;
    // ---------------------------------------------------------------
    // Register map (byte addresses = printed offset index times four)
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] IDX_PORT_B_DATA = 8'h01;
    localparam logic [7:0] IDX_PORT_C_DATA = 8'h02;
    localparam logic [7:0] IDX_PORT_D_DATA = 8'h03;
    localparam logic [7:0] IDX_PORT_B_DIR = 8'h04;
    localparam logic [7:0] IDX_PORT_C_DIR = 8'h05;
    localparam logic [7:0] IDX_PORT_D_DIR = 8'h06;
    localparam logic [7:0] IDX_PORT_C_PUE = 8'h07;
    localparam logic [7:0] IDX_PORT_D_PUE = 8'h08;
    localparam logic [7:0] IDX_PERIPH_CTRL = 8'h09;
    // ---------------------------------------------------------------
    // Peripheral control register fields
    // ---------------------------------------------------------------
    localparam int unsigned BIT_CAN_EN = 0;
    localparam int unsigned BIT_SPI_EN = 1;
    localparam int unsigned BIT_SPI_MSTR = 2;
    localparam int unsigned BIT_T1CH0_EN = 3;
    localparam int unsigned BIT_TIMER1_CHANNEL1_PIN_EN = 4;
    localparam int unsigned BIT_T2CH0_EN = 5;
    localparam int unsigned BIT_TIMER2_CHANNEL1_PIN_EN = 6;
    localparam int unsigned CTRL_W = 7;
    // ---------------------------------------------------------------
    // Reset values and responses
    // ---------------------------------------------------------------
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] PUE_RST = 8'h00;
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [6:0] PORT_C_MASK = 7'h7f;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== dv/gpp_board.sv ====
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Board circuitry on the port pins
// ---------------------------------------------------------------
module gpp_board #(
    parameter int unsigned W = 8
) (
    input wire logic i_ref_clk,
    input wire logic [W-1:0] i_out,
    input wire logic [W-1:0] i_oe,
    input wire logic [W-1:0] i_pu,
    input wire logic [W-1:0] i_ext,
    input wire logic [W-1:0] i_ext_en,
    output logic [W-1:0] o_pin
);
    // Floating pins toggle, so a stale level never passes for a driven one
    logic [W-1:0] last_reg = '0;
    always_ff @(posedge i_ref_clk) begin
        last_reg <= o_pin;
    end
    assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
        | (~i_oe & ~i_ext_en & (i_pu | ~last_reg));
endmodule // gpp_board

// ==== dv/gpp_ports_props.sv ====
`timescale 1ns/1ns
module gpp_ports_props (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_analog_inputs_low,
    input wire logic [7:0] o_port_b_oe,
    input wire logic [7:0] o_port_b_analog,
    input wire logic [6:0] i_port_c_pin,
    input wire logic [6:0] o_port_c_out,
    input wire logic [6:0] o_port_c_oe,
    input wire logic [6:0] o_port_c_pullup,
    input wire logic i_can_tx,
    input wire logic o_can_rx,
    input wire logic [7:0] o_port_d_oe,
    input wire logic [7:0] o_port_d_pullup,
    input wire logic [7:0] i_periph_oe,
    input wire logic o_serial_periph_enable,
    input wire logic o_serial_master_select,
    input wire logic o_can_pin_enable,
    input wire logic [3:0] o_edge_level_select
);
    // ---------------------------------------------------------------
    // Pin ownership and reset
    // ---------------------------------------------------------------
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    AST_B_ANALOG: assert property (o_port_b_analog == i_analog_inputs_low
        && (o_port_b_oe & i_analog_inputs_low) == 8'h00) else $error("analog pin driven");
    AST_C_PULL: assert property ((o_port_c_pullup & o_port_c_oe) == 7'h00)
        else $error("port c pullup on output");
    AST_D_PULL: assert property ((o_port_d_pullup & o_port_d_oe) == 8'h00)
        else $error("port d pullup on output");
    AST_CAN: assert property (o_can_pin_enable |-> o_can_rx == i_port_c_pin[1]
        && o_port_c_out[0] == i_can_tx && o_port_c_oe[1:0] == 2'b01) else $error("can pins");
    AST_SPI: assert property (o_serial_periph_enable
        |-> o_port_d_oe[3:1] == i_periph_oe[3:1]) else $error("spi pins not owned");
    AST_SS: assert property (o_serial_periph_enable && !o_serial_master_select
        |-> o_port_d_oe[0] == i_periph_oe[0]) else $error("select pin not owned");
    AST_T1: assert property (o_edge_level_select[1]
        |-> o_port_d_oe[7] == i_periph_oe[7]) else $error("timer 1 pin not owned");
    AST_T2: assert property (o_edge_level_select[3]
        |-> o_port_d_oe[5] == i_periph_oe[5]) else $error("timer 2 pin not owned");
    AST_RST_DIR: assert property ($fell(i_rst) |-> o_port_b_oe == 8'h00
        && o_port_c_oe == 7'h00 && o_port_d_oe == 8'h00) else $error("outputs after reset");
endmodule // gpp_ports_props
bind gpp_ports gpp_ports_props u_gpp_ports_props (.*);

// ==== dv/gpp_ports_tb_top.sv ====
`timescale 1ns/1ns
module gpp_ports_tb_top;
    import gpp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0;
    logic rready = 1'b0, can_tx = 1'b0, clk_en = 1'b1;
    logic [3:0] strb = 4'hf;
    logic [7:0] pe_out = 8'h00;
    logic [7:0] awaddr = '0, araddr = '0, an = '0, ext_b = '0, ext_d = '0, pe_oe = '0;
    logic [31:0] wdata = '0, rd;
    logic [1:0] rs;
    wire awr, wrdy, bv, arr, rv;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] pb, pb_o, pb_e, pd, pd_o, pd_e, pd_u;
    wire [6:0] pc, pc_o, pc_e, pc_u;
    int miscompares = 0, n_tests = 0, cyc = 0;
    gpp_ports u_gpp_ports (.i_ref_clk(clk), .i_rst(rst), .i_clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
        .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rready), .i_analog_inputs_low(an), .i_port_b_pin(pb),
        .o_port_b_out(pb_o), .o_port_b_oe(pb_e), .o_port_b_analog(), .i_port_c_pin(pc),
        .o_port_c_out(pc_o), .o_port_c_oe(pc_e), .o_port_c_pullup(pc_u), .i_can_tx(can_tx),
        .o_can_rx(), .i_port_d_pin(pd), .o_port_d_out(pd_o), .o_port_d_oe(pd_e),
        .o_port_d_pullup(pd_u), .i_periph_out(pe_out), .i_periph_oe(pe_oe), .o_periph_in(),
        .o_serial_periph_enable(), .o_serial_master_select(), .o_can_pin_enable(),
        .o_edge_level_select());
    gpp_board #(.W(8)) u_board_b (.i_ref_clk(clk), .i_out(pb_o), .i_oe(pb_e), .i_pu(8'h00),
        .i_ext(ext_b), .i_ext_en(8'hff), .o_pin(pb));
    gpp_board #(.W(7)) u_board_c (.i_ref_clk(clk), .i_out(pc_o), .i_oe(pc_e), .i_pu(pc_u),
        .i_ext(7'h00), .i_ext_en(7'h00), .o_pin(pc));
    gpp_board #(.W(8)) u_board_d (.i_ref_clk(clk), .i_out(pd_o), .i_oe(pd_e), .i_pu(pd_u),
        .i_ext(ext_d), .i_ext_en(8'hff), .o_pin(pd));
    // ---------------------------------------------------------------
    // Bus tasks and checks
    // ---------------------------------------------------------------
    initial forever #4 clk = ~clk;
    function automatic logic [7:0] ba(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (awr && !ad) begin
                ad = 1'b1;
                awv <= 1'b0;
            end
            if (wrdy && !dd) begin
                dd = 1'b1;
                wv <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (!bv);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        araddr <= a;
        arv <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (!rv);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        rdr(ba(idx));
        chk(nm, rd, exp);
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        rchk("b_dir", IDX_PORT_B_DIR, 32'h0);
        rchk("c_dir", IDX_PORT_C_DIR, 32'h0);
        rchk("d_dir", IDX_PORT_D_DIR, 32'h0);
        rchk("c_pue", IDX_PORT_C_PUE, 32'h0);
        ext_b <= 8'h3c;
        repeat (3) @(posedge clk);
        rchk("b_in", IDX_PORT_B_DATA, 32'h3c);
    endtask
    task automatic t_b();
        wr(ba(IDX_PORT_B_DATA), 32'ha5);
        chk("wr_ok", rs, RESP_OKAY);
        wr(ba(IDX_PORT_B_DIR), 32'h0f);
        chk("b_oe", pb_e, 8'h0f);
        rchk("b_mix", IDX_PORT_B_DATA, 32'h35);
        wr(ba(IDX_PORT_B_DATA), 32'h5a);
        rchk("b_wr_in", IDX_PORT_B_DATA, 32'h3a);
        an <= 8'h01;
        @(posedge clk);
        chk("b_an", pb_e, 8'h0e);
        an <= 8'h00;
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("b_oe_rst", pb_e, 8'h00);
        wr(ba(IDX_PORT_B_DIR), 32'hff);
        rchk("b_keep", IDX_PORT_B_DATA, 32'h5a);
    endtask
    task automatic t_c();
        wr(ba(IDX_PORT_C_DATA), 32'h55);
        wr(ba(IDX_PORT_C_DIR), 32'h0f);
        wr(ba(IDX_PORT_C_PUE), 32'hff);
        chk("c_pu", pc_u, 7'h70);
        rchk("c_mix", IDX_PORT_C_DATA, 32'h75);
        rchk("c_bit7", IDX_PORT_C_PUE, 32'h7f);
        wr(ba(IDX_PERIPH_CTRL), 32'h01);
        can_tx <= 1'b1;
        @(posedge clk);
        chk("c_tx", pc_o[0], 1'b1);
        can_tx <= 1'b0;
        wr(ba(IDX_PERIPH_CTRL), 32'h00);
        chk("c_gpio", pc_e, 7'h0f);
    endtask
    task automatic t_d();
        ext_d <= 8'h96;
        pe_oe <= 8'h02;
        wr(ba(IDX_PORT_D_DATA), 32'h0f);
        wr(ba(IDX_PORT_D_DIR), 32'hff);
        wr(ba(IDX_PORT_D_PUE), 32'hff);
        chk("d_pu", pd_u, 8'h00);
        wr(ba(IDX_PERIPH_CTRL), 32'h02);
        chk("d_spi", pd_e, 8'hf2);
        rchk("d_rd", IDX_PORT_D_DATA, 32'h0f);
        wr(ba(IDX_PERIPH_CTRL), 32'h06);
        chk("d_mstr", pd_e, 8'hf3);
        wr(ba(IDX_PERIPH_CTRL), 32'h1e);
        chk("d_t1", pd_e, 8'h33);
        wr(ba(IDX_PERIPH_CTRL), 32'h60);
        chk("d_t2", pd_e, 8'hcf);
        wr(ba(IDX_PERIPH_CTRL), 32'h00);
        wr(ba(IDX_PORT_D_DIR), 32'h00);
        chk("d_pu_in", pd_u, 8'hff);
        rchk("d_pin", IDX_PORT_D_DATA, 32'h96);
    endtask
    task automatic t_misc();
        pe_out <= 8'h80;
        wr(ba(IDX_PERIPH_CTRL), 32'h10);
        chk("d_t1_out", pd_o[7], 1'b1);
        strb <= 4'h0;
        wr(ba(IDX_PERIPH_CTRL), 32'h00);
        chk("strb_resp", rs, RESP_OKAY);
        strb <= 4'hf;
        rchk("strb_keep", IDX_PERIPH_CTRL, 32'h10);
        clk_en <= 1'b0;
        @(posedge clk);
        chk("ce_awr", awr, 1'b0);
        chk("ce_arr", arr, 1'b0);
        clk_en <= 1'b1;
        pe_out <= 8'h00;
        @(posedge clk);
        wr(ba(IDX_PERIPH_CTRL), 32'h00);
        chk("d_gpio_out", pd_o[7], 1'b0);
    endtask
    task automatic t_err();
        wr(8'hfc, 32'h01);
        chk("wr_err", rs, RESP_SLVERR);
        rdr(8'hfc);
        chk("rd_err", rs, RESP_SLVERR);
    endtask
    task automatic conclude();
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Ceiling is over twenty times the fewer than 200 cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_b();
        t_c();
        t_d();
        t_misc();
        t_err();
        conclude();
    end
endmodule // gpp_ports_tb_top
